// file: bwdp_ctrl.sv
// Controller side of a DRAM channel burst write: command, strobe, data and spacing
// Functional notes
// - Each command is sent as chip select and six address lines, sampled on rising clock.
// - Column bits 3:2 go out low and bits 1:0 are never sent, so bursts are aligned.
// - Write latency counts from the last rising edge of the column second command.
// - The strobe is driven for a two clock preamble before its first latching edge.
// - After the last beat the strobe keeps toggling for a half or one and a half clocks.
// - No precharge to the bank is allowed until write recovery has elapsed.
// - Write recovery counts from the first clock rise after the last latching edge.
// - A read waits write latency plus one plus half the burst plus write to read delay.
// - Write to read delay counts from the first clock rise after the last latching edge.
// - Strobe timing is retrained periodically to stay centred in the valid window.
// - A started burst always runs to its end; burst length is chosen per command.
// - The postamble length is set through mode register write commands.
`include "bwdp_cfg.svh"
module bwdp_ctrl
#(
  parameter int unsigned TRAIN_CK = `BWDP_TRAIN_CK
)
(
  // Clock, reset, clock enable
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    ce_in,
  // Write request
  input  wire logic                    req_valid_in,
  input  wire logic [2:0]              req_bank_in,
  input  wire logic [9:4]              req_col_in,
  input  wire logic                    req_bl32_in,
  output logic                         req_ready_out,
  // Configuration
  input  wire logic [5:0]              write_latency_in,
  input  wire logic                    post_long_in,
  // Write data stream
  input  wire bwdp_pkg::bwdp_word_type wdata_in,
  output logic                         data_take_out,
  // Memory pins
  output logic                         ck_t_out,
  output logic                         ck_c_out,
  output logic                         cs_out,
  output bwdp_pkg::bwdp_ca_type        command_address_bus_out,
  output logic                         dqs_t_out,
  output logic                         dqs_c_out,
  output logic                         dqs_oe_n_out,
  output bwdp_pkg::bwdp_word_type      dq_out,
  output logic [1:0]                   mask_invert_lane_out,
  output logic                         dq_oe_n_out,
  // Spacing and training status
  output logic                         rd_ok_out,
  output logic                         pre_ok_out,
  output logic                         train_due_out,
  input  wire logic                    train_done_in
);
  import bwdp_pkg::*;

  bwdp_state_type st_q;
  bwdp_state_type st_d;
  logic [1:0]     ph_q;
  logic [7:0]     cnt_q;
  logic [7:0]     wl_q;
  logic [2:0]     bank_q;
  logic [9:4]     col_q;
  logic           bl32_q;
  logic           post_q;
  logic           prog_post_q;
  logic           ready_q;
  logic           take_q;
  logic [7:0]     take_cnt_q;
  logic           cs_d;
  bwdp_ca_type    ca_d;
  logic           wr_done;
  logic           wtr_done;
  logic           train_done;
  logic           train_done_prev_q;
  logic           ck_t_q;
  logic           ck_c_q;
  logic           cs_q;
  bwdp_ca_type    ca_q;
  logic           dqs_t_q;
  logic           dqs_c_q;
  logic           dqs_oe_n_q;
  bwdp_word_type  dq_q;
  logic [1:0]     mil_q;
  logic           dq_oe_n_q;
  logic           rd_ok_q;
  logic           pre_ok_q;
  logic           train_due_q;

  // Memory clock ticks once per four system cycles
  wire        tick     = (ph_q == 2'h3);
  wire        accept   = ready_q && req_valid_in && tick;
  wire        in_burst = (st_q == ST_BURST);
  wire [7:0]  bl_len   = bl32_q ? 8'h20 : 8'h10;
  wire [7:0]  half_bl  = bl32_q ? 8'h10 : 8'h08;
  wire [7:0]  h        = {cnt_q[6:0], ph_q[1]};
  wire [7:0]  h_end    = `BWDP_PRE_HALVES + bl_len + (post_q ? 8'h03 : 8'h01);
  wire        drv      = in_burst && (h < h_end);
  wire        dqs_val  = (h >= 8'h02) && !h[0];
  wire        win      = in_burst && (h >= 8'h03) && (h <= bl_len + 8'h02);
  wire        start    = tick && in_burst && (cnt_q == 8'h01 + half_bl);
  wire [3:0]  s1       = {1'b0, cnt_q[2:0]} + {3'h0, ph_q[1]};
  wire        slot_act = (st_q == ST_CMD || st_q == ST_MRW) && s1 >= 4'h1 && s1 <= 4'h4;
  wire [1:0]  slot     = 2'(s1 - 4'h1);
  wire [7:0]  mr_op    = 8'({7'h00, post_q} << `BWDP_MR_POST_BIT);

  // Phase of the generated clock
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ph_q <= 2'h0;
    else if (ce_in)
      ph_q <= ph_q + 2'h1;
  end

  // Sequencer: one request at a time, no burst is ever abandoned
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      ST_IDLE:
        if (accept)
          st_d = (post_long_in != prog_post_q) ? ST_MRW : ST_CMD;
      ST_MRW:
        if (tick && cnt_q == 8'h04)
          st_d = ST_CMD;
      ST_CMD:
        if (tick && cnt_q == 8'h04)
          st_d = ST_LAT;
      ST_LAT:
        if (tick && cnt_q == wl_q - 8'h04)
          st_d = ST_BURST;
      ST_BURST:
        if (tick && cnt_q == 8'h02 + half_bl + {7'h00, post_q})
          st_d = ST_IDLE;
      default:
        st_d = ST_IDLE;
    endcase
  end

  // State and memory clock count within the state
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      st_q  <= ST_IDLE;
      cnt_q <= 8'h00;
    end
    else if (ce_in)
    begin
      st_q <= st_d;
      if (st_d != st_q)
        cnt_q <= 8'h00;
      else if (tick)
        cnt_q <= cnt_q + 8'h01;
    end
  end

  // Request capture; ready stands only in a tick cycle
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ready_q     <= 1'b0;
      wl_q        <= 8'h04;
      bank_q      <= 3'h0;
      col_q       <= 6'h00;
      bl32_q      <= 1'b0;
      post_q      <= 1'b0;
      prog_post_q <= 1'b0;
    end
    else if (ce_in)
    begin
      ready_q <= (st_q == ST_IDLE) && (ph_q == 2'h2);
      if (accept)
      begin
        wl_q   <= {2'h0, write_latency_in};
        bank_q <= req_bank_in;
        col_q  <= req_col_in;
        bl32_q <= req_bl32_in;
        post_q <= post_long_in;
      end
      // Device now holds the new postamble
      if (st_q == ST_MRW && st_d == ST_CMD)
        prog_post_q <= post_q;
    end
  end

  // Command slots change mid clock so they are stable at the rising edge
  always_comb
  begin
    cs_d = 1'b0;
    ca_d = 6'h00;
    if (slot_act)
    begin
      case (slot)
        2'h0:
        begin
          cs_d = 1'b1;
          ca_d = (st_q == ST_MRW) ? {mr_op[7], `BWDP_MRW1_OP} : {bl32_q, `BWDP_WR1_OP};
        end
        2'h1:
          ca_d = (st_q == ST_MRW) ? `BWDP_MR_POST_ADDR : {1'b0, col_q[9], 1'b0, bank_q};
        2'h2:
        begin
          cs_d = 1'b1;
          ca_d = (st_q == ST_MRW) ? {mr_op[6], `BWDP_MRW2_OP} : {col_q[8], `BWDP_CAS2_OP};
        end
        2'h3:
          ca_d = (st_q == ST_MRW) ? mr_op[5:0] : {col_q[7:4], 2'h0};
        default:
          ca_d = 6'h00;
      endcase
    end
  end

  // Clock and command pins
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ck_t_q <= 1'b0;
      ck_c_q <= 1'b1;
      cs_q   <= 1'b0;
      ca_q   <= 6'h00;
    end
    else if (ce_in)
    begin
      ck_t_q <= !ph_q[1];
      ck_c_q <= ph_q[1];
      cs_q   <= cs_d;
      ca_q   <= ca_d;
    end
  end

  // Strobe: static low, one toggle, a beat per edge, then the postamble
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      dqs_t_q    <= 1'b0;
      dqs_c_q    <= 1'b0;
      dqs_oe_n_q <= 1'b1;
    end
    else if (ce_in)
    begin
      dqs_t_q    <= drv && dqs_val;
      dqs_c_q    <= drv && !dqs_val;
      dqs_oe_n_q <= !drv;
    end
  end

  // Data changes between strobe edges, so each beat is centred on its edge
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      take_q     <= 1'b0;
      take_cnt_q <= 8'h00;
      dq_q       <= 16'h0000;
      mil_q      <= 2'h0;
      dq_oe_n_q  <= 1'b1;
    end
    else if (ce_in)
    begin
      take_q <= win && !ph_q[0];
      if (accept)
        take_cnt_q <= 8'h00;
      else if (take_q)
        take_cnt_q <= take_cnt_q + 8'h01;
      if (take_q)
        dq_q <= wdata_in;
      mil_q     <= 2'h0;
      dq_oe_n_q <= !(in_burst && h >= 8'h03 && h <= bl_len + 8'h03);
    end
  end

  // recovery from first rise after burst
  bwdp_timer u_wr
  (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .tick_in  (tick),
    .load_in  (start),
    .count_in (20'(`BWDP_WR_CK + 1)),
    .done_out (wr_done)
  );

  // write to read from same edge
  bwdp_timer u_wtr
  (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .tick_in  (tick),
    .load_in  (start),
    .count_in (20'(`BWDP_WTR_CK + 1)),
    .done_out (wtr_done)
  );

  // Retraining interval restarts when training completes
  bwdp_timer u_train
  (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .ce_in    (ce_in),
    .tick_in  (tick),
    .load_in  (train_done_in),
    .count_in (20'(TRAIN_CK)),
    .done_out (train_done)
  );

  // Spacing flags stay low for the whole write so no early read slips in
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rd_ok_q           <= 1'b0;
      pre_ok_q          <= 1'b0;
      train_due_q       <= 1'b0;
      train_done_prev_q <= 1'b0;
    end
    else if (ce_in)
    begin
      rd_ok_q  <= wtr_done && (st_d == ST_IDLE);
      pre_ok_q <= wr_done && (st_d == ST_IDLE);
      train_done_prev_q <= train_done;
      train_due_q <= (train_done && !train_done_prev_q) || (train_due_q && !train_done_in);
    end
  end

  assign req_ready_out           = ready_q;
  assign data_take_out           = take_q;
  assign ck_t_out                = ck_t_q;
  assign ck_c_out                = ck_c_q;
  assign cs_out                  = cs_q;
  assign command_address_bus_out = ca_q;
  assign dqs_t_out               = dqs_t_q;
  assign dqs_c_out               = dqs_c_q;
  assign dqs_oe_n_out            = dqs_oe_n_q;
  assign dq_out                  = dq_q;
  assign mask_invert_lane_out    = mil_q;
  assign dq_oe_n_out             = dq_oe_n_q;
  assign rd_ok_out               = rd_ok_q;
  assign pre_ok_out              = pre_ok_q;
  assign train_due_out           = train_due_q;

  // Checks assume the clock enable stays high during a write
  localparam int WTR_CLKS = 4 * (`BWDP_WTR_CK + 1) + 12;
  localparam int WR_CLKS  = 4 * (`BWDP_WR_CK + 1) + 12;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_CS_IN_CMD: assert property (cs_q |-> $past(st_q == ST_CMD || st_q == ST_MRW))
    else $error("chip select outside a command");
  AST_COL_LOW: assert property ((st_q == ST_CMD && slot_act && slot == 2'h3)
    |=> (ca_q[1:0] == 2'h0 && !cs_q)) else $error("column bits 3:2 not low");
  AST_WL_SPAN: assert property ($rose(in_burst)
    |-> ($past(st_q) == ST_LAT && $past(cnt_q) == wl_q - 8'h04)) else $error("latency wrong");
  AST_PREAMBLE: assert property ((in_burst && h == 8'h04 && ph_q == 2'h0)
    |-> ($past(drv, 8) && !$past(dqs_val, 8) && $past(dqs_val, 4)))
    else $error("preamble not two clocks");
  AST_BEATS: assert property ($fell(in_burst) |-> take_cnt_q == bl_len)
    else $error("beat count differs from burst length");
  AST_POSTAMBLE: assert property ($fell(drv)
    |-> $past(h) == 8'h03 + bl_len + (post_q ? 8'h03 : 8'h01)) else $error("postamble length");
  AST_PRE_BLOCK: assert property ((st_q != ST_IDLE) |-> !pre_ok_q)
    else $error("precharge allowed during write");
  AST_RECOVERY: assert property (start |=> !pre_ok_q [*8] ##[1:WR_CLKS] pre_ok_q)
    else $error("recovery window wrong");
  AST_RD_BLOCK: assert property ((st_q != ST_IDLE) |-> !rd_ok_q)
    else $error("read allowed during write");
  AST_WTR: assert property (start |=> !rd_ok_q [*8] ##[1:WTR_CLKS] rd_ok_q)
    else $error("write to read window wrong");
  AST_NO_CUT: assert property ($rose(in_burst) |-> in_burst [*8])
    else $error("burst cut short");
  AST_MRW_FIRST: assert property ((accept && post_long_in != prog_post_q) |=> st_q == ST_MRW)
    else $error("postamble change without mode write");

  COV_BL16: cover property ($fell(in_burst) && !bl32_q);
  COV_BL32: cover property ($fell(in_burst) && bl32_q);
  COV_MRW: cover property ($rose(st_q == ST_MRW));
  COV_LONG_POST: cover property ($fell(drv) && post_q);
endmodule // bwdp_ctrl

// file: bwdp_cfg.svh
// Timing counts, command encodings and mode register fields of the burst write controller
`ifndef BWDP_CFG_SVH
`define BWDP_CFG_SVH
// System clock period and system cycles per generated memory clock
`define BWDP_CLK_NS       5
`define BWDP_CK_CLKS      4
`define BWDP_CK_NS        (`BWDP_CLK_NS * `BWDP_CK_CLKS)
// Write preamble in strobe half periods (two memory clocks)
`define BWDP_PRE_HALVES   8'h04
// Command opcode fields carried on the low five address lines of a first half
`define BWDP_WR1_OP       5'h04
`define BWDP_CAS2_OP      5'h12
`define BWDP_MRW1_OP      5'h06
`define BWDP_MRW2_OP      5'h16
// Mode register that holds the write postamble length, and its bit
`define BWDP_MR_POST_ADDR 6'h03
`define BWDP_MR_POST_BIT  1
// Write recovery and write to read times, and their counts in memory clocks
`define BWDP_WR_TIME_NS   18
`define BWDP_WTR_TIME_NS  10
`define BWDP_WR_CK        ((`BWDP_WR_TIME_NS + `BWDP_CK_NS - 1) / `BWDP_CK_NS)
`define BWDP_WTR_CK       ((`BWDP_WTR_TIME_NS + `BWDP_CK_NS - 1) / `BWDP_CK_NS)
// Strobe retraining interval in memory clocks
`define BWDP_TRAIN_CK     100000
`endif

// file: bwdp_pkg.sv
// Types shared by the burst write controller
package bwdp_pkg;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_MRW   = 5'h02,
    ST_CMD   = 5'h04,
    ST_LAT   = 5'h08,
    ST_BURST = 5'h10
  } bwdp_state_type;
  typedef logic [5:0]  bwdp_ca_type;
  typedef logic [15:0] bwdp_word_type;
  typedef logic [19:0] bwdp_count_type;
endpackage

// file: bwdp_timer.sv
// Down counter in memory clock ticks with a done level
module bwdp_timer
(
  // Clock and reset
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic                     ce_in,
  // Control
  input  wire logic                     tick_in,
  input  wire logic                     load_in,
  input  wire bwdp_pkg::bwdp_count_type count_in,
  // Status
  output logic                          done_out
);
  import bwdp_pkg::*;

  bwdp_count_type cnt_q;

  // Load wins over counting so a restart is never lost
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      cnt_q <= 20'h00000;
    else if (ce_in)
    begin
      if (load_in)
        cnt_q <= count_in;
      else if (tick_in && cnt_q != 20'h00000)
        cnt_q <= cnt_q - 20'h00001;
    end
  end

  assign done_out = (cnt_q == 20'h00000);
endmodule // bwdp_timer

// file: bwdp_dev_model.sv
// Behavioural memory device that decodes commands and captures write bursts
`include "bwdp_cfg.svh"
module bwdp_dev_model
(
  // Command pins
  input wire logic        ck_t_in,
  input wire logic        cs_in,
  input wire logic [5:0]  ca_in,
  // Strobe and data pins
  input wire logic        dqs_t_in,
  input wire logic        dqs_oe_n_in,
  input wire logic [15:0] dq_in,
  input wire logic        dq_oe_n_in,
  input wire logic [1:0]  mil_in,
  // Write latency as programmed
  input wire logic [5:0]  wl_in
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam real HALF = `BWDP_CK_NS / 2.0;
  logic [6:0]  h [0:3] = '{default: 7'h00};
  logic [2:0]  bank_q;
  logic [9:4]  col_q;
  logic        bl32_q;
  logic        post_q = 1'b0;
  logic [15:0] words [0:31];
  logic        armed = 1'b0;
  logic        done = 1'b0;
  int          beats, nbl, wr_cnt = 0, err_cnt = 0;
  realtime     t_e, t_first, t_oe, t_last, t_prev;

  task automatic flag(input string msg);
    err_cnt++;
    $display("Error %0t: device %s", $realtime, msg);
  endtask

  // Command slots, one per clock rise; a frame is first, second, first, second
  // sampled slots
  always @(posedge ck_t_in)
  begin
    h[0] = h[1];
    h[1] = h[2];
    h[2] = h[3];
    h[3] = {cs_in, ca_in};
    if (h[0][6] && !h[1][6] && h[2][6] && !h[3][6])
    begin
      if (h[0][4:0] == `BWDP_MRW1_OP && h[1][5:0] == `BWDP_MR_POST_ADDR
          && h[2][4:0] == `BWDP_MRW2_OP)
        post_q = h[3][`BWDP_MR_POST_BIT];
      else if (h[0][4:0] == `BWDP_WR1_OP && h[2][4:0] == `BWDP_CAS2_OP)
      begin
        if (h[3][1:0] != 2'b00)
          flag("column bits 3:2 set");
        bl32_q = h[0][5];
        bank_q = h[1][2:0];
        col_q = {h[1][4], h[2][5], h[3][5:2]};
        nbl = bl32_q ? 32 : 16;
        t_e = $realtime;
        t_first = t_e + wl_in * `BWDP_CK_NS;
        if (armed)
          flag("write before burst end");
        beats = 0;
        armed = 1'b1;
      end
    end
  end

  // Capture on every strobe edge once the first latching edge is due
  // preamble and capture
  always @(dqs_t_in)
  begin
    if (armed && $realtime > t_first - 1.0)
    begin
      if (beats == 0 && ($realtime != t_first || dqs_t_in !== 1'b1))
        flag("first latching edge misplaced");
      if (beats == 0 && t_first - t_oe < 2 * `BWDP_CK_NS)
        flag("preamble short");
      if (beats > 0 && $realtime - t_prev != HALF)
        flag("strobe edges not consecutive");
      if (dqs_oe_n_in || dq_oe_n_in || mil_in != 2'b00)
        flag("strobe or data not driven");
      words[beats] = dq_in;
      t_prev = $realtime;
      beats++;
      if (beats == nbl)
      begin
        armed = 1'b0;
        done = 1'b1;
        t_last = $realtime;
        wr_cnt++;
      end
    end
  end

  // Start of strobe drive marks the preamble
  always @(negedge dqs_oe_n_in) t_oe = $realtime;

  // Strobe release: never mid burst, and only after the selected postamble
  // postamble and completion
  always @(posedge dqs_oe_n_in)
  begin
    if (armed)
      flag("burst cut short");
    if (done && ($realtime - t_last < (post_q ? 3 : 1) * HALF
        || $realtime - t_last > (post_q ? 4 : 2) * HALF))
      flag("postamble length wrong");
    done = 1'b0;
  end
endmodule // bwdp_dev_model

// file: tb_burst_write_data_path.sv
// Testbench of the burst write controller against the device model
`include "bwdp_cfg.svh"
module tb_burst_write_data_path;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TRAIN = 20;
  logic                    clk_in, rst_in, ce_in, req_valid_in, req_bl32_in;
  logic                    post_long_in, train_done_in;
  logic [2:0]              req_bank_in;
  logic [9:4]              req_col_in;
  logic [5:0]              write_latency_in;
  bwdp_pkg::bwdp_word_type wdata_in, dq_out, data_base;
  bwdp_pkg::bwdp_ca_type   ca;
  logic                    ready, take, ck_t, ck_c, cs, dqs_t, dqs_c, dqs_oe_n, dq_oe_n;
  logic                    rd_ok, pre_ok, train_due;
  logic [1:0]              mil;
  int                      miscompares = 0, total_checks = 0, cycles = 0, idx = 0;
  realtime                 t_rd, t_pre;

  bwdp_ctrl #(.TRAIN_CK(TRAIN)) dut
  (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .req_valid_in(req_valid_in), .req_bank_in(req_bank_in), .req_col_in(req_col_in),
    .req_bl32_in(req_bl32_in), .req_ready_out(ready),
    .write_latency_in(write_latency_in), .post_long_in(post_long_in),
    .wdata_in(wdata_in), .data_take_out(take),
    .ck_t_out(ck_t), .ck_c_out(ck_c), .cs_out(cs), .command_address_bus_out(ca),
    .dqs_t_out(dqs_t), .dqs_c_out(dqs_c), .dqs_oe_n_out(dqs_oe_n),
    .dq_out(dq_out), .mask_invert_lane_out(mil), .dq_oe_n_out(dq_oe_n),
    .rd_ok_out(rd_ok), .pre_ok_out(pre_ok), .train_due_out(train_due),
    .train_done_in(train_done_in)
  );

  bwdp_dev_model dev
  (
    .ck_t_in(ck_t), .cs_in(cs), .ca_in(ca), .dqs_t_in(dqs_t), .dqs_oe_n_in(dqs_oe_n),
    .dq_in(dq_out), .dq_oe_n_in(dq_oe_n), .mil_in(mil), .wl_in(write_latency_in)
  );

  // Free running system clock
  initial
  begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
  end

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles == 10000)
    begin
      miscompares++;
      test_done();
    end
  end

  // Data source has no valid: the next word must already wait when taken
  always @(negedge clk_in) wdata_in <= data_base + 16'(idx);
  always @(posedge clk_in) if (take === 1'b1) idx <= idx + 1;
  always @(posedge rd_ok) t_rd = $realtime;
  always @(posedge pre_ok) t_pre = $realtime;

  // Differential pairs must stay complementary whenever they are driven
  always @(negedge clk_in)
    if (!rst_in && (ck_c !== ~ck_t || (dqs_oe_n === 1'b0 && dqs_c !== ~dqs_t)))
    begin
      miscompares++;
      $display("Error %0t: complementary pin pair broken", $realtime);
    end

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1)
    begin
      miscompares++;
      $display("Error %0t: %s", $realtime, msg);
    end
  endtask

  task automatic test_done();
    if (miscompares == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // One write through request, command, burst and spacing release
  task automatic do_write(input logic [2:0] bank, input logic [9:4] col, input logic bl32,
                          input logic post, input logic [5:0] wl);
    int n, cnt0, lim;
    n = bl32 ? 32 : 16;
    cnt0 = dev.wr_cnt;
    lim = 0;
    @(negedge clk_in);
    {req_bank_in, req_col_in, req_bl32_in, post_long_in} = {bank, col, bl32, post};
    write_latency_in = wl;
    data_base = {bank, col, 7'h00};
    idx = 0;
    req_valid_in = 1'b1;
    while (ready !== 1'b1 && lim < 40)
    begin
      @(negedge clk_in);
      lim++;
    end
    @(negedge clk_in);
    req_valid_in = 1'b0;
    check(lim < 40, "request not taken");
    repeat (2) @(negedge clk_in);
    check(rd_ok === 1'b0 && pre_ok === 1'b0, "spacing flags high");
    while ((dev.wr_cnt == cnt0 || ready !== 1'b1 || rd_ok !== 1'b1 || pre_ok !== 1'b1)
           && lim < 4000)
    begin
      @(negedge clk_in);
      lim++;
    end
    check(lim < 4000 && dev.err_cnt == 0, "burst refused");
    check(dev.bank_q === bank && dev.col_q === col, "bank or column");
    check(dev.bl32_q === bl32 && idx == n, "burst length");
    check(dev.post_q === post, "postamble setting");
    for (int i = 0; i < n; i++)
      check(dev.words[i] === data_base + 16'(i), "captured word");
    check(t_rd >= dev.t_e + (wl + 1 + n / 2 + `BWDP_WTR_CK) * `BWDP_CK_NS - `BWDP_CLK_NS
          && t_rd <= dev.t_last + (4 * `BWDP_WTR_CK + 18) * `BWDP_CLK_NS, "read gap");
    check(t_pre >= dev.t_e + (wl + 1 + n / 2 + `BWDP_WR_CK) * `BWDP_CK_NS - `BWDP_CLK_NS
          && t_pre <= dev.t_last + (4 * `BWDP_WR_CK + 18) * `BWDP_CLK_NS, "precharge gap");
  endtask

  // Pin levels while reset is held
  task automatic test_reset_values();
    repeat (4) @(negedge clk_in);
    check(ready === 1'b0 && take === 1'b0 && ck_t === 1'b0 && ck_c === 1'b1, "reset pins");
    check(cs === 1'b0 && ca === 6'h00 && dqs_oe_n === 1'b1 && dq_oe_n === 1'b1, "reset bus");
    check(mil === 2'b00 && rd_ok === 1'b0 && pre_ok === 1'b0 && train_due === 1'b0, "reset status");
  endtask

  // Shortest latency, 16 beats, short postamble
  task automatic test_bl16_short();
    do_write(3'h3, 6'h2A, 1'b0, 1'b0, 6'd4);
  endtask

  // 32 beats with long postamble, so a mode write goes first
  task automatic test_bl32_long();
    do_write(3'h5, 6'h15, 1'b1, 1'b1, 6'd9);
  endtask

  // Back to back writes changing burst length and postamble per command
  task automatic test_bl_on_the_fly();
    do_write(3'h7, 6'h3F, 1'b0, 1'b1, 6'd6);
    do_write(3'h0, 6'h00, 1'b1, 1'b0, 6'd5);
  endtask

  // Retraining request cleared by the done pulse and raised again after the interval
  task automatic test_training();
    int lim;
    lim = 0;
    @(negedge clk_in);
    check(train_due === 1'b1, "retraining not requested");
    train_done_in = 1'b1;
    @(negedge clk_in);
    train_done_in = 1'b0;
    @(negedge clk_in);
    check(train_due === 1'b0, "request not cleared");
    while (train_due !== 1'b1 && lim < 200)
    begin
      @(negedge clk_in);
      lim++;
    end
    check(lim >= 4 * TRAIN - 8 && lim <= 4 * TRAIN + 8, "retraining interval");
  endtask

  // Clock enable low while idle freezes the generated clock and the request slot
  task automatic test_clock_enable();
    logic ck0, rdy0;
    @(negedge clk_in);
    ce_in = 1'b0;
    ck0 = ck_t;
    rdy0 = ready;
    repeat (8)
    begin
      @(negedge clk_in);
      check(ck_t === ck0 && ready === rdy0, "state moved with clock enable low");
    end
    ce_in = 1'b1;
    repeat (2) @(negedge clk_in);
    check(ck_t === ~ck0, "memory clock did not resume");
  endtask

  // Main sequence
  initial
  begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    req_valid_in = 1'b0;
    req_bl32_in = 1'b0;
    post_long_in = 1'b0;
    train_done_in = 1'b0;
    req_bank_in = 3'h0;
    req_col_in = 6'h00;
    write_latency_in = 6'h04;
    wdata_in = 16'h0000;
    data_base = 16'h0000;
    test_reset_values();
    repeat (8) @(negedge clk_in);
    rst_in = 1'b0;
    test_bl16_short();
    test_bl32_long();
    test_bl_on_the_fly();
    test_training();
    test_clock_enable();
    test_done();
  end
endmodule // tb_burst_write_data_path
